// *** hdl/tmr_pkg.sv ***
// Package with register map, field layout and constants of the 8-bit timer
package tmr_pkg;

  // Register addresses on the plain register port
  localparam logic [7:0] TMR_ADDR_PSC   = 8'hD2;
  localparam logic [7:0] TMR_ADDR_CNT   = 8'hD3;
  localparam logic [7:0] TMR_ADDR_CTL   = 8'hD4;
  localparam logic [7:0] TMR_ADDR_ISTAT = 8'hD5;
  localparam logic [7:0] TMR_ADDR_IMASK = 8'hD6;

  // Reset and reload values
  localparam logic [6:0] TMR_PSC_RST    = 7'h7F;
  localparam logic [7:0] TMR_CNT_RST    = 8'hFF;
  localparam logic [7:0] TMR_CTL_RST    = 8'h00;
  localparam logic [6:0] TMR_PSC_ZERO   = 7'h00;
  localparam logic [7:0] TMR_CNT_ZERO   = 8'h00;
  localparam logic [1:0] TMR_IRQ_RST    = 2'h0;
  localparam logic [7:0] TMR_RD_IDLE    = 8'h00;

  // Field positions of status_control
  localparam int TMR_CTL_FLAG    = 7;
  localparam int TMR_CTL_IEN     = 6;
  localparam int TMR_CTL_DIR     = 5;
  localparam int TMR_CTL_DOUT    = 4;
  localparam int TMR_CTL_RUN     = 3;
  localparam int TMR_CTL_DIV_MSB = 2;
  localparam int TMR_CTL_DIV_LSB = 0;

  // Event bits of the interrupt status and mask registers
  localparam int TMR_IEV_UNDER = 0;
  localparam int TMR_IEV_PIN   = 1;

  // Internal clock divider in front of the prescaler (divide by 12)
  localparam int         TMR_INT_DIV      = 12;
  localparam logic [3:0] TMR_INT_DIV_LAST = 4'(TMR_INT_DIV - 1);
  localparam logic [3:0] TMR_INT_DIV_ZERO = 4'h0;

  // Prescaler clock source, picked from direction and data output bits
  typedef enum logic [1:0] {
    TMR_MODE_EVENT,
    TMR_MODE_GATED,
    TMR_MODE_OUTPUT
  } tmr_mode_e;

  // Low-bit mask of the prescaler tap: 2**sel - 1
  function automatic logic [6:0] tmr_tap_mask(input logic [2:0] sel);
    logic [7:0] tmp;
    tmp = 8'(8'h01 << sel) - 8'h01;
    return tmp[6:0];
  endfunction

endpackage

// *** hdl/tmr_timer.sv ***
// Eight-bit down-counting timer with seven-bit prescaler and timer pin
//
// Functional notes
// - Prescaler read gives zero in bit 7 and the live count below.
// - Reset: prescaler 7Fh, counter FFh, status/control 00h.
// - Counter readable and writable at any time, all eight bits.
// - Underflow flag sets when the counter passes from 00h to FFh.
// - Interrupt request while enable is one and the flag or an unmasked event bit is set, none otherwise.
// - Direction bit zero makes the pin input, one a push-pull output.
// - Output mode: data bit goes to pin on flag rise; input: selects mode.
// - Run bit zero holds prescaler at 7Fh and freezes counter.
// - Divider select picks tap dividing by 2**select, 1 up to 128.
// - Registers at D2h, D3h, D4h; status/control fields as laid out.
// - Underflow interrupt can wake the processor from wait and stop.
// - Counter reloads FFh after zero, steps once per tap rising edge.
// - Gated mode: prescaler steps on divided clock only while pin high.
// - Event mode: prescaler steps on each rising edge of the pin.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ns
module tmr_timer
  import tmr_pkg::*;
(
  input  wire logic       i_clk,    // System clock, 20 MHz
  input  wire logic       i_rst_n,  // Synchronous reset, active low
  input  wire logic [7:0] i_addr,   // Register address
  input  wire logic [7:0] i_wdata,  // Write data
  input  wire logic       i_wr,     // Write strobe
  input  wire logic       i_rd,     // Read strobe
  output logic      [7:0] o_rdata,  // Read data, cycle after strobe
  input  wire logic       i_pin_i,  // Timer pin level in
  output logic            o_pin_o,  // Timer pin level out
  output logic            o_pin_oe, // Timer pin drive enable
  output logic            o_irq     // Level interrupt and wake request
);

  logic [6:0] psc_ff, nxt_psc;
  logic [7:0] cnt_ff, nxt_cnt;
  logic       flag_ff, nxt_flag;
  logic       ien_ff, nxt_ien;
  logic       dir_ff, nxt_dir;
  logic       dout_ff, nxt_dout;
  logic       run_ff, nxt_run;
  logic [2:0] div_ff, nxt_div;
  logic [3:0] div12_ff, nxt_div12;
  logic       pin_s1_ff, pin_s2_ff, pin_s3_ff;
  logic [1:0] istat_ff, nxt_istat;
  logic [1:0] imask_ff, nxt_imask;
  logic [7:0] rdata_ff, nxt_rdata;
  logic       irq_ff, nxt_irq;
  logic       pin_o_ff, nxt_pin_o;
  logic       pin_oe_ff, nxt_pin_oe;

  logic       wr_psc, wr_cnt, wr_ctl, wr_istat, wr_imask;
  logic       int_tick, pin_rise, psc_clk, psc_step, tap_fire;
  logic       underflow, flag_set, flag_rise;
  logic [1:0] ev_set, ev_clr;
  tmr_mode_e  mode;

  // Register decode and clock source selection
  always_comb begin
    wr_psc   = i_wr && (i_addr == TMR_ADDR_PSC);
    wr_cnt   = i_wr && (i_addr == TMR_ADDR_CNT);
    wr_ctl   = i_wr && (i_addr == TMR_ADDR_CTL);
    wr_istat = i_wr && (i_addr == TMR_ADDR_ISTAT);
    wr_imask = i_wr && (i_addr == TMR_ADDR_IMASK);
    int_tick = (div12_ff == TMR_INT_DIV_LAST);
    // Edge seen on second and third stage only, never the first
    pin_rise = pin_s2_ff && !pin_s3_ff;
    // Input mode uses the data bit as mode select
    if (dir_ff) begin
      mode = TMR_MODE_OUTPUT;
    end else if (dout_ff) begin
      mode = TMR_MODE_GATED;
    end else begin
      mode = TMR_MODE_EVENT;
    end
    // Default first, so the source mux can never hold a latch
    psc_clk = 1'b0;
    unique case (mode)
      TMR_MODE_EVENT: begin
        psc_clk = pin_rise;
      end
      TMR_MODE_GATED: begin
        psc_clk = int_tick && pin_s2_ff;
      end
      TMR_MODE_OUTPUT: begin
        psc_clk = int_tick;
      end
    endcase
    psc_step = run_ff && psc_clk;
    // Tap rises when the low select bits wrap from zero
    tap_fire = psc_step &&
               ((psc_ff & tmr_tap_mask(div_ff)) == TMR_PSC_ZERO);
  end

  // Next values of prescaler, counter and divide-by-12
  always_comb begin
    nxt_div12 = int_tick ? TMR_INT_DIV_ZERO : div12_ff + 4'h1;
    if (!run_ff) begin
      nxt_psc = TMR_PSC_RST;
    end else if (wr_psc) begin
      nxt_psc = i_wdata[6:0];
    end else if (psc_step) begin
      nxt_psc = (psc_ff == TMR_PSC_ZERO) ? TMR_PSC_RST : psc_ff - 7'h01;
    end else begin
      nxt_psc = psc_ff;
    end
    // Software write wins over a decrement in the same cycle
    underflow = !wr_cnt && tap_fire && (cnt_ff == TMR_CNT_ZERO);
    if (wr_cnt) begin
      nxt_cnt = i_wdata;
    end else if (tap_fire) begin
      nxt_cnt = (cnt_ff == TMR_CNT_ZERO) ? TMR_CNT_RST :
                cnt_ff - 8'h01;
    end else begin
      nxt_cnt = cnt_ff;
    end
  end

  // Next values of status/control and the timer pin
  always_comb begin
    nxt_ien  = wr_ctl ? i_wdata[TMR_CTL_IEN]  : ien_ff;
    nxt_dir  = wr_ctl ? i_wdata[TMR_CTL_DIR]  : dir_ff;
    nxt_dout = wr_ctl ? i_wdata[TMR_CTL_DOUT] : dout_ff;
    nxt_run  = wr_ctl ? i_wdata[TMR_CTL_RUN]  : run_ff;
    nxt_div  = wr_ctl ? i_wdata[TMR_CTL_DIV_MSB:TMR_CTL_DIV_LSB] : div_ff;
    // Hardware set beats a software clear in the same cycle
    flag_set = underflow ||
               (wr_cnt && (i_wdata == TMR_CNT_ZERO)) ||
               (wr_ctl && i_wdata[TMR_CTL_FLAG]);
    if (flag_set) begin
      nxt_flag = 1'b1;
    end else if (wr_ctl) begin
      nxt_flag = 1'b0;
    end else begin
      nxt_flag = flag_ff;
    end
    flag_rise  = nxt_flag && !flag_ff;
    // Data bit is latched on flag rise, seen on the pin when driving
    nxt_pin_o  = flag_rise ? nxt_dout : pin_o_ff;
    nxt_pin_oe = nxt_dir;
  end

  // Interrupt status, mask and request
  always_comb begin
    ev_set = 2'h0;
    ev_set[TMR_IEV_UNDER] = underflow;
    ev_set[TMR_IEV_PIN]   = pin_rise;
    ev_clr    = wr_istat ? i_wdata[1:0] : 2'h0;
    nxt_istat = (istat_ff & ~ev_clr) | ev_set;
    nxt_imask = wr_imask ? i_wdata[1:0] : imask_ff;
    // Enable gates every source, so a zero enable means no request;
    // the same level serves as wake-up in wait and stop
    nxt_irq   = nxt_ien &&
                (nxt_flag || (|(nxt_istat & nxt_imask)));
  end

  // Read data, valid only in the cycle after the strobe
  always_comb begin
    nxt_rdata = TMR_RD_IDLE;
    if (i_rd) begin
      unique case (i_addr)
        TMR_ADDR_PSC:   nxt_rdata = {1'b0, psc_ff};
        TMR_ADDR_CNT:   nxt_rdata = cnt_ff;
        TMR_ADDR_CTL:   nxt_rdata = {flag_ff, ien_ff, dir_ff, dout_ff,
                                     run_ff, div_ff};
        TMR_ADDR_ISTAT: nxt_rdata = {6'h00, istat_ff};
        TMR_ADDR_IMASK: nxt_rdata = {6'h00, imask_ff};
        default:        nxt_rdata = TMR_RD_IDLE;
      endcase
    end
  end

  // State registers; the pin synchroniser runs through reset as well
  always_ff @(posedge i_clk) begin
    pin_s1_ff <= i_pin_i;
    pin_s2_ff <= pin_s1_ff;
    pin_s3_ff <= pin_s2_ff;
    if (!i_rst_n) begin
      psc_ff    <= TMR_PSC_RST;
      cnt_ff    <= TMR_CNT_RST;
      {flag_ff, ien_ff, dir_ff, dout_ff, run_ff, div_ff} <= TMR_CTL_RST;
      div12_ff  <= TMR_INT_DIV_ZERO;
      istat_ff  <= TMR_IRQ_RST;
      imask_ff  <= TMR_IRQ_RST;
      rdata_ff  <= TMR_RD_IDLE;
      irq_ff    <= 1'b0;
      pin_o_ff  <= 1'b0;
      pin_oe_ff <= 1'b0;
    end else begin
      psc_ff    <= nxt_psc;
      cnt_ff    <= nxt_cnt;
      flag_ff   <= nxt_flag;
      ien_ff    <= nxt_ien;
      dir_ff    <= nxt_dir;
      dout_ff   <= nxt_dout;
      run_ff    <= nxt_run;
      div_ff    <= nxt_div;
      div12_ff  <= nxt_div12;
      istat_ff  <= nxt_istat;
      imask_ff  <= nxt_imask;
      rdata_ff  <= nxt_rdata;
      irq_ff    <= nxt_irq;
      pin_o_ff  <= nxt_pin_o;
      pin_oe_ff <= nxt_pin_oe;
    end
  end

  // Outputs straight from flip-flops
  assign o_rdata  = rdata_ff;
  assign o_irq    = irq_ff;
  assign o_pin_o  = pin_o_ff;
  assign o_pin_oe = pin_oe_ff;

  // Checks on the timer behaviour
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  property p_psc_read;
    i_rd && (i_addr == TMR_ADDR_PSC) |=>
      (o_rdata[7] == 1'b0) && (o_rdata[6:0] == $past(psc_ff));
  endproperty
  a_psc_read: assert property (p_psc_read)
    else $error("prescaler read shows wrong data");

  property p_reset_vals;
    @(posedge i_clk) disable iff (1'b0)
    !i_rst_n |=> (psc_ff == TMR_PSC_RST) && (cnt_ff == TMR_CNT_RST) &&
                 !flag_ff && !run_ff && !o_pin_oe && !o_irq;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("reset values wrong");

  property p_cnt_write;
    // Write, an idle cycle with no step, then a read of the counter
    wr_cnt ##1 (!i_wr && !tap_fire) ##1 (i_rd && (i_addr == TMR_ADDR_CNT))
      |=> o_rdata == $past(i_wdata, 3);
  endproperty
  a_cnt_write: assert property (p_cnt_write)
    else $error("counter write not read back");

  property p_underflow;
    tap_fire && (cnt_ff == TMR_CNT_ZERO) && !wr_cnt |=>
      (cnt_ff == TMR_CNT_RST) && flag_ff;
  endproperty
  a_underflow: assert property (p_underflow)
    else $error("underflow did not reload or set flag");

  property p_flag_sticky;
    flag_ff && !wr_ctl |=> flag_ff;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("flag cleared without software");

  property p_irq_level;
    ##1 (o_irq == (ien_ff && (flag_ff || (|(istat_ff & imask_ff)))));
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt level does not follow flag and enable");

  property p_irq_off;
    !ien_ff |-> !o_irq;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("interrupt request with enable off");

  property p_pin_dir;
    wr_ctl |=> o_pin_oe == $past(i_wdata[TMR_CTL_DIR]);
  endproperty
  a_pin_dir: assert property (p_pin_dir)
    else $error("pin drive enable does not follow direction");

  property p_pin_hold;
    !wr_ctl |=> $stable(o_pin_oe);
  endproperty
  a_pin_hold: assert property (p_pin_hold)
    else $error("pin drive enable moved without a control write");

  property p_pin_latch;
    flag_rise |=> o_pin_o == dout_ff;
  endproperty
  a_pin_latch: assert property (p_pin_latch)
    else $error("data bit not latched to pin on flag rise");

  property p_hold;
    !run_ff && !wr_cnt |=> (psc_ff == TMR_PSC_RST) && $stable(cnt_ff);
  endproperty
  a_hold: assert property (p_hold)
    else $error("prescaler or counter moved while stopped");

  property p_gated;
    run_ff && (mode == TMR_MODE_GATED) && !pin_s2_ff && !wr_psc |=>
      $stable(psc_ff);
  endproperty
  a_gated: assert property (p_gated)
    else $error("prescaler stepped with gate low");

  property p_event;
    run_ff && (mode == TMR_MODE_EVENT) && pin_rise && !wr_psc |=>
      !$stable(psc_ff);
  endproperty
  a_event: assert property (p_event)
    else $error("prescaler missed a pin edge");

  property p_tap_div1;
    psc_step && (div_ff == 3'h0) && !wr_cnt |=> cnt_ff != $past(cnt_ff);
  endproperty
  a_tap_div1: assert property (p_tap_div1)
    else $error("counter did not step on every prescaler step");

  c_underflow: cover property (underflow ##1 o_irq);
  c_pin_out:   cover property (dir_ff && flag_rise ##1 o_pin_o);
  c_event:     cover property (run_ff && (mode == TMR_MODE_EVENT) &&
                               tap_fire);
  c_gated:     cover property (run_ff && (mode == TMR_MODE_GATED) &&
                               psc_step);

endmodule

// *** tb/tmr_pin_src.sv ***
// Model of the signal source that sits on the timer pin
`timescale 1ns/1ns
module tmr_pin_src (
  input  wire logic i_clk,    // System clock
  input  wire logic i_dut_oe, // High while the device drives the pin
  output logic      o_lvl,    // Level put on the pin
  output logic      o_drv     // High while this model drives
);
  // Back off once the device drives, so the two never fight on the wire
  assign o_drv = !i_dut_oe;
  initial o_lvl = 1'b0;

  // Steady level for gated counting, changed just after an edge
  task automatic hold(input logic v);
    @(posedge i_clk);
    o_lvl <= v;
  endtask

  // Pulses three clocks high and three low, wide enough for the synchroniser
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge i_clk);
      o_lvl <= 1'b1;
      repeat (3) @(posedge i_clk);
      o_lvl <= 1'b0;
      repeat (2) @(posedge i_clk);
    end
  endtask
endmodule

// *** tb/test_tmr_timer.sv ***
// Self-checking testbench of the eight-bit prescaled timer
`timescale 1ns/1ns
module test_tmr_timer;
  import tmr_pkg::*;
  logic       i_clk = 1'b0;
  logic       i_rst_n = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic       i_wr = 1'b0;
  logic       i_rd = 1'b0;
  logic [7:0] o_rdata;
  logic       o_pin_o;
  logic       o_pin_oe;
  logic       o_irq;
  logic       src_lvl;
  logic       src_drv;
  logic       pin_w;
  logic       rd_d = 1'b0;
  logic [7:0] exp_q[$];
  logic [7:0] v;
  logic [7:0] exp_v;
  int         failures = 0;
  int         cmp_count = 0;

`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin failures++; \
  $display("unexpected at %0t: got %h exp %h", $time, a, e); end end

  always #25 i_clk = ~i_clk;
  // Wire level: device, else source, else the pull-up
  assign pin_w = o_pin_oe ? o_pin_o : (src_drv ? src_lvl : 1'b1);

  tmr_timer u_tmr_timer (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_pin_i(pin_w), .o_pin_o(o_pin_o), .o_pin_oe(o_pin_oe), .o_irq(o_irq));
  tmr_pin_src u_tmr_pin_src (.i_clk(i_clk), .i_dut_oe(o_pin_oe),
    .o_lvl(src_lvl), .o_drv(src_drv));

  // Read data stand only in the cycle after the strobe, so check them there
  always @(posedge i_clk) begin
    if (rd_d) begin
      // Pop once: the macro names its expected value twice
      exp_v = exp_q.pop_front();
      `CHK(o_rdata, exp_v)
    end
    rd_d <= i_rd;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  // Note the expected value, then issue the read
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clk);
    exp_q.push_back(e);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
  endtask

  // Registered outputs land on the same edge that takes the write
  task automatic settle();
    repeat (2) @(negedge i_clk);
  endtask

  task automatic wait_pin(input logic lv);
    for (int k = 0; k < 100 && o_pin_o !== lv; k++) @(negedge i_clk);
    `CHK(o_pin_o, lv)
  endtask

  task automatic complete_run();
    $display("comparisons %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Hang guard, well above the expected run of about 2000 cycles
  initial begin
    #(50 * 20000);
    failures++;
    complete_run();
  end

  initial begin
    void'($urandom(32'h60EF));
    repeat (12) @(posedge i_clk);
    i_rst_n <= 1'b1;
    // Reset values, and an unmapped address reads as zero
    rd(TMR_ADDR_PSC, 8'h7F);
    rd(TMR_ADDR_CNT, 8'hFF);
    rd(TMR_ADDR_CTL, 8'h00);
    rd(8'h10, 8'h00);
    wr(8'h10, 8'h5A);
    settle();
    `CHK(o_irq, 1'b0)
    `CHK(o_pin_oe, 1'b0)
    // Counter written and read while frozen; prescaler write ignored
    repeat (4) begin
      v = 8'($urandom_range(255, 1));
      wr(TMR_ADDR_CNT, v);
      rd(TMR_ADDR_CNT, v);
    end
    wr(TMR_ADDR_PSC, 8'h15);
    rd(TMR_ADDR_PSC, 8'h7F);
    // Each tap needs 2**sel pin events for one counter step
    for (int n = 0; n < 8; n++) begin
      wr(TMR_ADDR_CTL, 8'h00);
      rd(TMR_ADDR_PSC, 8'h7F);
      wr(TMR_ADDR_CNT, 8'h05);
      wr(TMR_ADDR_CTL, 8'h08 | 8'(n));
      u_tmr_pin_src.pulses(1 << n);
      repeat (6) @(posedge i_clk);
      rd(TMR_ADDR_CNT, 8'h04);
      if (n < 7) rd(TMR_ADDR_PSC, 8'(8'h7F - (1 << n)));
    end
    // Underflow from 00h to FFh sets the flag, no request with enable off
    wr(TMR_ADDR_CTL, 8'h08);
    wr(TMR_ADDR_CNT, 8'h01);
    u_tmr_pin_src.pulses(2);
    repeat (30) @(posedge i_clk);
    rd(TMR_ADDR_CNT, 8'hFF);
    rd(TMR_ADDR_CTL, 8'h88);
    `CHK(o_irq, 1'b0)
    wr(TMR_ADDR_CTL, 8'hC8);
    settle();
    `CHK(o_irq, 1'b1)
    wr(TMR_ADDR_CTL, 8'h48);
    settle();
    `CHK(o_irq, 1'b0)
    rd(TMR_ADDR_CTL, 8'h48);
    // Sticky event bits, mask and write-one clear
    wr(TMR_ADDR_IMASK, 8'h01);
    settle();
    `CHK(o_irq, 1'b1)
    rd(TMR_ADDR_ISTAT, 8'h03);
    wr(TMR_ADDR_ISTAT, 8'h03);
    settle();
    `CHK(o_irq, 1'b0)
    rd(TMR_ADDR_ISTAT, 8'h00);
    wr(TMR_ADDR_IMASK, 8'h00);
    // Prescaler write taken while running; top bit reads zero
    wr(TMR_ADDR_PSC, 8'h95);
    rd(TMR_ADDR_PSC, 8'h15);
    // Gated mode with the pin high: 24 running clocks give two steps
    u_tmr_pin_src.hold(1'b1);
    wr(TMR_ADDR_CTL, 8'h10);
    wr(TMR_ADDR_CTL, 8'h18);
    repeat (23) @(posedge i_clk);
    rd(TMR_ADDR_PSC, 8'h7D);
    // Gated mode with the pin low: no prescaler steps
    u_tmr_pin_src.hold(1'b0);
    wr(TMR_ADDR_CTL, 8'h00);
    wr(TMR_ADDR_CTL, 8'h18);
    repeat (60) @(posedge i_clk);
    rd(TMR_ADDR_PSC, 8'h7F);
    // Output mode: data bit latched onto the pin at each flag rise
    wr(TMR_ADDR_CNT, 8'h01);
    wr(TMR_ADDR_CTL, 8'h38);
    settle();
    `CHK(o_pin_oe, 1'b1)
    `CHK(o_pin_o, 1'b0)
    wait_pin(1'b1);
    wr(TMR_ADDR_CTL, 8'h28);
    settle();
    `CHK(o_pin_o, 1'b1)
    wr(TMR_ADDR_CNT, 8'h01);
    wait_pin(1'b0);
    wr(TMR_ADDR_CTL, 8'h00);
    settle();
    `CHK(o_pin_oe, 1'b0)
    repeat (4) @(posedge i_clk);
    complete_run();
  end
endmodule
